// >>> include/dcaa_pkg.sv
package dcaa_pkg;
  // APB map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CMD_TX = 8'h00;  // Command transmit register
  localparam logic [7:0] OFF_DMODE = 8'h04;   // D-channel mode register
  localparam logic [7:0] OFF_IFCTRL = 8'h08;  // Interface control register
  localparam logic [7:0] OFF_STATUS = 8'h0C;  // Read-only block state
  // Command transmit register fields
  localparam int CMD_BACREQ_BIT = 0;          // Bus-accessed request
  localparam int CMD_ADDR_LSB = 1;            // Arbitration address field
  localparam int CMD_CODE_LSB = 4;            // Command channel code
  localparam logic [7:0] CMD_RESET = 8'hFE;   // Address 7, no request
  // D-channel mode register fields
  localparam int DMODE_LTT_BIT = 3;           // Non-terminal frame in LT-T
  localparam logic [3:0] DMODE_RESET = 4'h0;
  // Interface control register: arbitration bus switched off
  localparam int IFC_TICOFF_BIT = 4;
  localparam logic [7:0] IFC_RESET = 8'h00;
  // Activation request codes, values arbitrary
  localparam logic [3:0] CODE_AR_HIGH = 4'h8;
  localparam logic [3:0] CODE_AR_LOW = 4'h9;
  // Serial frame geometry
  localparam logic [6:0] FRAME_LAST = 7'h5F;  // 96 bits per frame
  localparam logic [6:0] CH2_LAST_OCT = 7'h58; // First bit of last octet
  localparam logic [2:0] BAC_POS = 3'h5;      // Bus-accessed / stop-go bit
  localparam logic [2:0] IDLE_ADDR = 3'h7;
  localparam logic [1:0] FREE_FRAMES = 2'h2;  // Free frames before rearm
  // Echo ones needed at normal level per class, and counter ceiling
  localparam logic [3:0] NEED_C1 = 4'h8;
  localparam logic [3:0] NEED_C2 = 4'hA;
  localparam logic [3:0] ONES_MAX = 4'hF;
  // Arbitration states
  typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_OWN, ST_HOLD} dcaa_state_t;
endpackage : dcaa_pkg

// >>> hw/dcaa_prio.sv
`timescale 1ns/10ps
// Echo-ones priority counter for S-bus D-channel access
module dcaa_prio (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_strobe,    // One echo bit per pulse
  input wire logic i_echo,      // Received echo bit
  input wire logic i_active,    // Collision detection enabled
  input wire logic i_class1,    // Signalling class selected
  input wire logic i_success,   // Own frame completed
  input wire logic i_collision, // Own frame aborted
  output logic o_go,            // Required ones reached
  output logic o_low_level      // Lower level of the class
);
  import dcaa_pkg::*;
  logic [3:0] ones_reg;         // Consecutive echo ones
  logic [3:0] need;             // Threshold for current level

  // Threshold: 8 or 10, one more at lower level
  always_comb begin
    need = i_class1 ? NEED_C1 : NEED_C2;
    if (o_low_level) begin
      need = need + 4'h1;
    end
  end

  // Count ones, restart on a zero or after an own frame
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ones_reg <= 4'h0;
    end else if (!i_active || i_success || i_collision) begin
      ones_reg <= 4'h0;
    end else if (i_strobe) begin
      if (!i_echo) begin
        ones_reg <= 4'h0;
      end else if (ones_reg != ONES_MAX) begin
        ones_reg <= ones_reg + 4'h1;
      end
    end
  end

  // Level drops after success, returns once lower count seen
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_low_level <= 1'b0;
    end else if (i_success) begin
      o_low_level <= 1'b1;
    end else if (o_low_level && ones_reg >= need) begin
      o_low_level <= 1'b0;
    end
  end

  // Go flag, registered
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_go <= 1'b0;
    end else begin
      o_go <= i_active && !i_success && !i_collision
              && ones_reg >= need;
    end
  end
endmodule : dcaa_prio

// >>> hw/dcaa_top.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module dcaa_top (
  input wire logic i_clock,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [dcaa_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial terminal bus pins
  input wire logic i_frame_sync,
  input wire logic i_bit_clock,
  input wire logic i_upstream_data_line,
  output logic o_upstream_data_line,
  output logic o_upstream_data_line_oe,
  output logic o_downstream_data_line,
  output logic o_stop_go_output_pin,
  // HDLC controller side
  input wire logic i_hdlc_pending,  // Frame awaits transmission
  input wire logic i_hdlc_signal,   // Frame carries signalling
  input wire logic i_hdlc_bit,      // Next D bit to send
  input wire logic i_hdlc_done,     // Frame sent completely
  output logic o_hdlc_grant,        // Arbitration bus owned
  output logic o_hdlc_tx,           // D bits going to S-bus
  output logic o_collision,         // Frame aborted, one pulse
  // S-bus transceiver side, same clock
  input wire logic i_s_strobe,      // One D/E bit slot
  input wire logic i_s_echo,        // Received echo bit
  output logic o_s_dbit             // D bit to transmit
);
  import dcaa_pkg::*;

  logic [2:0] meta_reg;             // First synchroniser stage
  logic [2:0] sync_reg;             // fsc, dcl, upstream line
  logic dcl_last_reg;               // For edge detection
  logic [6:0] bit_idx_reg;          // Bit position in frame
  logic [7:0] cmd_reg;              // Command transmit register
  logic [3:0] dmode_reg;            // D-channel mode register
  logic [7:0] ifc_reg;              // Interface control register
  dcaa_state_t state_reg;           // Arbitration state
  logic [1:0] addr_left_reg;        // Address bit in flight
  logic [1:0] free_cnt_reg;         // Free frames seen in hold
  logic class1_reg;                 // High priority class chosen
  logic s_tx_reg;                   // Transmitting on S-bus
  logic prio_go;
  logic prio_low;
  logic coll_now;
  logic dcl_rise;
  logic dcl_fall;
  logic du_s;
  logic tic_on;
  logic col_on;
  logic tic_req;
  logic apb_setup;
  logic apb_done;
  logic [2:0] my_addr;
  logic [6:0] idx_next;             // Index of the bit now starting

  // Position of an index within the last channel-2 octet
  function automatic logic in_oct(input logic [6:0] idx);
    in_oct = idx >= CH2_LAST_OCT;
  endfunction : in_oct

  function automatic logic [2:0] oct_bit(input logic [6:0] idx);
    logic [6:0] d;
    d = idx - CH2_LAST_OCT;
    oct_bit = 3'h7 - d[2:0];
  endfunction : oct_bit

  assign dcl_rise = sync_reg[1] && !dcl_last_reg;
  assign dcl_fall = !sync_reg[1] && dcl_last_reg;
  assign du_s = sync_reg[2];
  // Slot that begins at this bit-clock rise; drives must use it
  assign idx_next = (sync_reg[0] || bit_idx_reg == FRAME_LAST) ? 7'h00
                    : bit_idx_reg + 7'h01;
  assign my_addr = cmd_reg[CMD_ADDR_LSB +: 3];
  assign tic_on = dmode_reg[2:1] == 2'b00
                  && !ifc_reg[IFC_TICOFF_BIT];
  assign col_on = dmode_reg[2] == 1'b0 && dmode_reg[0];
  assign tic_req = cmd_reg[CMD_BACREQ_BIT] || i_hdlc_pending;
  assign coll_now = s_tx_reg && i_s_strobe && col_on
                    && (i_s_echo != o_s_dbit);
  assign apb_setup = i_psel && i_penable && !o_pready;
  assign apb_done = i_psel && i_penable && o_pready;

  // Two-flop synchronisers for pins
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // Idle interface levels: sync high, bit clock low, line high
      meta_reg <= 3'h5;
      sync_reg <= 3'h5;
      dcl_last_reg <= 1'b0;
    end else begin
      meta_reg <= {i_upstream_data_line, i_bit_clock, i_frame_sync};
      sync_reg <= meta_reg;
      dcl_last_reg <= sync_reg[1];
    end
  end

  // Bit index: frame sync at a rising bit clock marks bit 0
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_idx_reg <= FRAME_LAST;
    end else if (dcl_rise) begin
      bit_idx_reg <= idx_next;
    end
  end

  // APB: one wait state, then answer
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_setup;
      if (apb_setup) begin
        o_pslverr <= 1'b0;
        o_prdata <= 32'h0000_0000;
        if (i_paddr == OFF_CMD_TX) begin
          o_prdata <= {24'h000000, cmd_reg};
        end else if (i_paddr == OFF_DMODE) begin
          o_prdata <= {28'h0000000, dmode_reg};
        end else if (i_paddr == OFF_IFCTRL) begin
          o_prdata <= {24'h000000, ifc_reg};
        end else if (i_paddr == OFF_STATUS) begin
          o_prdata <= {22'h000000, free_cnt_reg, prio_low, prio_go,
                       s_tx_reg, o_stop_go_output_pin, state_reg,
                       o_hdlc_grant, o_hdlc_tx};
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // Register writes at the completing access edge
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_reg <= CMD_RESET;
      dmode_reg <= DMODE_RESET;
      ifc_reg <= IFC_RESET;
    end else if (apb_done && i_pwrite) begin
      if (i_paddr == OFF_CMD_TX) begin
        cmd_reg <= i_pwdata[7:0];
      end else if (i_paddr == OFF_DMODE) begin
        dmode_reg <= i_pwdata[3:0];
      end else if (i_paddr == OFF_IFCTRL) begin
        ifc_reg <= i_pwdata[7:0];
      end
    end
  end

  // Priority class follows the activation request code
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      class1_reg <= 1'b1;
    end else if (cmd_reg[CMD_CODE_LSB +: 4] == CODE_AR_HIGH) begin
      class1_reg <= 1'b1;
    end else if (cmd_reg[CMD_CODE_LSB +: 4] == CODE_AR_LOW) begin
      class1_reg <= 1'b0;
    end
  end

  // Arbitration state, sampled at the falling bit clock
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      addr_left_reg <= 2'h0;
      free_cnt_reg <= 2'h0;
    end else if (!tic_on) begin
      state_reg <= ST_IDLE;
      free_cnt_reg <= 2'h0;
    end else if (dcl_fall && in_oct(bit_idx_reg)) begin
      case (state_reg)
        ST_IDLE: begin
          if (oct_bit(bit_idx_reg) == BAC_POS && tic_req && du_s) begin
            state_reg <= ST_ARB;
            addr_left_reg <= 2'h2;
          end else if (oct_bit(bit_idx_reg) == 3'h0 && !tic_req
                       && my_addr == IDLE_ADDR && du_s) begin
            state_reg <= ST_ARB;
            addr_left_reg <= 2'h0;
          end
        end
        ST_ARB: begin
          if (oct_bit(bit_idx_reg) <= 3'h2) begin
            if (my_addr[addr_left_reg] && !du_s) begin
              state_reg <= ST_IDLE;
            end else if (addr_left_reg == 2'h0) begin
              state_reg <= ST_OWN;
            end else begin
              addr_left_reg <= addr_left_reg - 2'h1;
            end
          end
        end
        ST_OWN: begin
          if (oct_bit(bit_idx_reg) == BAC_POS && !tic_req) begin
            // Default owner yields only when another seizes the flag
            if (my_addr != IDLE_ADDR) begin
              state_reg <= ST_HOLD;
              free_cnt_reg <= 2'h0;
            end else if (!du_s) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_HOLD: begin
          if (oct_bit(bit_idx_reg) == BAC_POS) begin
            if (!du_s) begin
              free_cnt_reg <= 2'h0;
            end else if (free_cnt_reg + 2'h1 == FREE_FRAMES) begin
              state_reg <= ST_IDLE;
            end else begin
              free_cnt_reg <= free_cnt_reg + 2'h1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Upstream drive at the rising bit clock: zeros only
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_upstream_data_line <= 1'b1;
      o_upstream_data_line_oe <= 1'b0;
    end else if (dcl_rise) begin
      o_upstream_data_line <= 1'b1;
      o_upstream_data_line_oe <= 1'b0;
      if (tic_on && in_oct(idx_next)) begin
        if (state_reg == ST_OWN && !tic_req) begin
          o_upstream_data_line_oe <= 1'b0;
        end else if (state_reg == ST_OWN
                     && oct_bit(idx_next) == BAC_POS) begin
          o_upstream_data_line <= 1'b0;
          o_upstream_data_line_oe <= 1'b1;
        end else if (state_reg == ST_ARB && addr_left_reg != 2'h0
                     && oct_bit(idx_next) == {1'b0, addr_left_reg}
                     && !my_addr[addr_left_reg]) begin
          o_upstream_data_line <= 1'b0;
          o_upstream_data_line_oe <= 1'b1;
        end else if (state_reg == ST_ARB && addr_left_reg == 2'h0
                     && oct_bit(idx_next) == 3'h0
                     && !my_addr[0]) begin
          o_upstream_data_line <= 1'b0;
          o_upstream_data_line_oe <= 1'b1;
        end
      end
    end
  end

  // Downstream stop/go slot, ones elsewhere
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_downstream_data_line <= 1'b1;
    end else if (dcl_rise) begin
      if (in_oct(idx_next) && oct_bit(idx_next) == BAC_POS
          && col_on && !dmode_reg[DMODE_LTT_BIT]) begin
        o_downstream_data_line <= o_stop_go_output_pin;
      end else begin
        o_downstream_data_line <= 1'b1;
      end
    end
  end

  // Stop/go level: one is stop, zero is go
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_stop_go_output_pin <= 1'b1;
    end else begin
      o_stop_go_output_pin <= !(prio_go || s_tx_reg);
    end
  end

  // S-bus transmit: start on go, stop on collision or end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_tx_reg <= 1'b0;
      o_s_dbit <= 1'b1;
      o_collision <= 1'b0;
    end else begin
      o_collision <= coll_now;
      if (coll_now || i_hdlc_done || !i_hdlc_pending) begin
        s_tx_reg <= 1'b0;
        o_s_dbit <= 1'b1;
      end else if (i_s_strobe && s_tx_reg) begin
        o_s_dbit <= i_hdlc_bit;
      end else if (i_s_strobe && prio_go
                   && (o_hdlc_grant || !tic_on)) begin
        s_tx_reg <= 1'b1;
        o_s_dbit <= i_hdlc_bit;
      end
    end
  end

  // Grant and transmit flags toward the HDLC controller
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hdlc_grant <= 1'b0;
      o_hdlc_tx <= 1'b0;
    end else begin
      o_hdlc_grant <= state_reg == ST_OWN;
      o_hdlc_tx <= s_tx_reg;
    end
  end

  // Echo-ones priority counter
  dcaa_prio u_prio (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_strobe(i_s_strobe && !s_tx_reg),
    .i_echo(i_s_echo),
    .i_active(col_on),
    .i_class1(class1_reg || i_hdlc_signal),
    .i_success(i_hdlc_done && s_tx_reg),
    .i_collision(coll_now),
    .o_go(prio_go),
    .o_low_level(prio_low)
  );

  oe_zero_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_upstream_data_line_oe |-> !o_upstream_data_line)
    else $error("Upstream driven high");
  tic_off_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !tic_on |=> state_reg == ST_IDLE)
    else $error("Arbitration while disabled");
  lose_stop_a: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    tic_on && dcl_fall && state_reg == ST_ARB && in_oct(bit_idx_reg)
    && oct_bit(bit_idx_reg) <= 3'h2 && my_addr[addr_left_reg] && !du_s
    |=> state_reg == ST_IDLE)
    else $error("Lost arbitration not withdrawn");
  own_bac_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    tic_on && tic_req && state_reg == ST_OWN && dcl_rise
    && in_oct(idx_next) && oct_bit(idx_next) == BAC_POS
    |=> o_upstream_data_line_oe && !o_upstream_data_line)
    else $error("Bus-accessed flag not held");
  hold_two_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    $rose(state_reg == ST_IDLE) && $past(state_reg) == ST_HOLD
    |-> $past(free_cnt_reg) == 2'h1 && $past(du_s))
    else $error("Rearmed too early");
  coll_stop_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    coll_now |=> !s_tx_reg && o_s_dbit && o_collision)
    else $error("Collision not handled");
  go_start_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    $rose(s_tx_reg) |-> $past(prio_go))
    else $error("Transmit before enough ones");
  sg_level_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    s_tx_reg |=> !o_stop_go_output_pin)
    else $error("Stop shown while sending");
  sg_slot_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    dcl_rise && dmode_reg[DMODE_LTT_BIT] |=> o_downstream_data_line)
    else $error("Stop/go on line in LT-T");
endmodule : dcaa_top

// >>> tb/dcaa_far_end.sv
`timescale 1ns/10ps
// Far side: frame timing and one rival controller on the upstream line
module dcaa_far_end (
  input wire logic i_dut_bit,     // Block's upstream value
  input wire logic i_dut_oe,      // Block drives the line
  input wire logic i_contend,     // Rival arbitrates each frame
  input wire logic [2:0] i_addr,  // Rival arbitration address
  input wire logic i_occupy,      // Rival holds the flag busy
  output logic o_bit_clock,
  output logic o_frame_sync,
  output logic o_line,            // Wired level, pulled up
  output logic [6:0] o_index      // Slot now on the line
);
  logic drive_zero = 1'b0;  // Rival pulls the line low
  logic lost = 1'b0;        // Rival left this frame's arbitration
  logic [6:0] nxt;          // Slot after this one
  assign nxt = (o_index == 7'h5F) ? 7'h00 : o_index + 7'h01;
  // Released line floats high, a driven zero wins
  assign o_line = !(i_dut_oe && !i_dut_bit) && !drive_zero;
  // Free running bit clock, phase unrelated to the system clock
  initial begin
    o_bit_clock = 1'b0;
    o_index = 7'h5F;
    o_frame_sync = 1'b0;
    #7.3;
    forever #40 o_bit_clock = ~o_bit_clock;
  end
  // Slot count, sync and drive on the bit clock rise
  always @(posedge o_bit_clock) begin
    o_index <= nxt;
    o_frame_sync <= (nxt == 7'h00);
    drive_zero <= (nxt == 7'h5A && i_occupy) || (i_contend && !lost &&
      nxt > 7'h5C && !i_addr[2'(7'h5F - nxt)]);
  end
  // Sample on the fall; a one read back as zero ends the attempt
  always @(negedge o_bit_clock) begin
    if (o_index == 7'h00) begin
      lost <= 1'b0;
    end else if (i_contend && o_index > 7'h5C && !o_line &&
      i_addr[2'(7'h5F - o_index)]) begin
      lost <= 1'b1;
    end
  end
endmodule : dcaa_far_end

// >>> tb/dcaa_top_tb_top.sv
`timescale 1ns/10ps
// Bench: APB tasks, frame slot sampling, S-side echo strobes
module dcaa_top_tb_top;
  import dcaa_pkg::*;
  logic i_clock, i_reset_n, psel, pen, pwr, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic fs, bck, line, up, up_oe, dn, sg, pend, sig, hbit, done;
  logic grant, tx, coll, stb_s, echo, s_d, contend, occupy, coll_seen;
  logic [6:0] idx;
  logic [32:0] rq[$];  // Expected {pslverr, prdata} of each read
  int err_total, compares;
  dcaa_top i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_frame_sync(fs), .i_bit_clock(bck),
    .i_upstream_data_line(line), .o_upstream_data_line(up),
    .o_upstream_data_line_oe(up_oe), .o_downstream_data_line(dn),
    .o_stop_go_output_pin(sg), .i_hdlc_pending(pend),
    .i_hdlc_signal(sig), .i_hdlc_bit(hbit), .i_hdlc_done(done),
    .o_hdlc_grant(grant), .o_hdlc_tx(tx), .o_collision(coll),
    .i_s_strobe(stb_s), .i_s_echo(echo), .o_s_dbit(s_d));
  dcaa_far_end i_far (.i_dut_bit(up), .i_dut_oe(up_oe),
    .i_contend(contend), .i_addr(3'h0), .i_occupy(occupy),
    .o_bit_clock(bck), .o_frame_sync(fs), .o_line(line), .o_index(idx));
  // System clock, 10 ns
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Counts and reports one comparison
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Single level compare
  task automatic cb(input logic got, input logic exp);
    chk({32'h0, got}, {32'h0, exp});
  endtask : cb
  // Closing report
  task automatic summarize;
    $display("Mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // A wait ran out
  task automatic hang;
    err_total++;
    summarize();
  endtask : hang
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Read with the expected answer noted first
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Wait until a slot is on the line and settled
  task automatic slot(input logic [6:0] s);
    int n;
    n = 0;
    while (idx !== s && n < 2000) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 2000) hang();
    repeat (6) @(posedge i_clock);
  endtask : slot
  // Let whole frames pass
  task automatic frames(input int k);
    repeat (k) begin
      slot(7'h00);
      slot(7'h01);
    end
  endtask : frames
  // Echo strobes with one echo value, D bits random
  task automatic stb(input logic e, input int k);
    repeat (k) begin
      @(posedge i_clock);
      stb_s <= 1'b1;
      echo <= e;
      hbit <= 1'($urandom);
      @(posedge i_clock);
      stb_s <= 1'b0;
      // Let go, stop/go and transmit flags settle before checks
      repeat (3) @(posedge i_clock);
    end
  endtask : stb
  // Read results and collision pulses are caught here
  always @(posedge i_clock) begin
    if (psel && pen && !pwr && pready === 1'b1) begin
      chk({pslverr, prdata}, rq.pop_front());
    end
    if (coll === 1'b1) coll_seen <= 1'b1;
  end
  // Main sequence
  initial begin
    void'($urandom(32'h8039));
    {i_reset_n, psel, pen, pwr, paddr, pwdata} = '0;
    {pend, sig, hbit, done, stb_s, echo, contend, occupy} = '0;
    {coll_seen, err_total, compares} = '0;
    repeat (5) @(posedge i_clock);
    i_reset_n <= 1'b1;
    chk({29'h0, sg, grant, tx, s_d}, 33'h9);
    rd(OFF_CMD_TX, {25'h0, CMD_RESET});
    rd(OFF_DMODE, 33'h0);
    rd(OFF_IFCTRL, 33'h0);
    rd(8'h10, 33'h100000000);
    frames(3);
    cb(grant, 1'b1);
    apb(1'b1, OFF_CMD_TX, 32'h6);
    frames(3);
    cb(grant, 1'b0);
    apb(1'b1, OFF_DMODE, 32'h2);
    apb(1'b1, OFF_CMD_TX, 32'h7);
    frames(3);
    cb(grant, 1'b0);
    apb(1'b1, OFF_IFCTRL, 32'h10);
    apb(1'b1, OFF_DMODE, 32'h0);
    frames(3);
    cb(grant, 1'b0);
    apb(1'b1, OFF_IFCTRL, 32'h0);
    frames(3);
    cb(grant, 1'b1);
    slot(7'h5A);
    cb(line, 1'b0);
    apb(1'b1, OFF_CMD_TX, 32'h6);
    frames(3);
    cb(grant, 1'b0);
    slot(7'h5A);
    cb(line, 1'b1);
    contend <= 1'b1;
    apb(1'b1, OFF_CMD_TX, 32'h7);
    frames(3);
    cb(grant, 1'b0);
    occupy <= 1'b1;
    contend <= 1'b0;
    frames(3);
    cb(grant, 1'b0);
    occupy <= 1'b0;
    frames(4);
    cb(grant, 1'b1);
    apb(1'b1, OFF_IFCTRL, 32'h10);
    apb(1'b1, OFF_CMD_TX, {24'h0, CODE_AR_LOW, 4'h6});
    apb(1'b1, OFF_DMODE, 32'h1);
    stb(1'b0, 1);
    stb(1'b1, 9);
    cb(sg, 1'b1);
    stb(1'b1, 1);
    cb(sg, 1'b0);
    slot(7'h5A);
    cb(dn, 1'b0);
    sig <= 1'b1;
    stb(1'b0, 1);
    stb(1'b1, 5);
    stb(1'b0, 1);
    stb(1'b1, 7);
    cb(sg, 1'b1);
    stb(1'b1, 1);
    cb(sg, 1'b0);
    pend <= 1'b1;
    stb(1'b1, 1);
    cb(tx, 1'b1);
    stb(!s_d, 1);
    cb(coll_seen, 1'b1);
    cb(tx, 1'b0);
    cb(s_d, 1'b1);
    stb(1'b0, 1);
    stb(1'b1, 9);
    cb(tx, 1'b1);
    @(posedge i_clock);
    done <= 1'b1;
    @(posedge i_clock);
    done <= 1'b0;
    pend <= 1'b0;
    stb(1'b0, 1);
    stb(1'b1, 8);
    cb(sg, 1'b1);
    stb(1'b1, 1);
    cb(sg, 1'b0);
    apb(1'b1, OFF_DMODE, 32'h9);
    slot(7'h5A);
    cb(dn, 1'b1);
    cb(sg, 1'b0);
    sig <= 1'b0;
    apb(1'b1, OFF_CMD_TX, {24'h0, CODE_AR_HIGH, 4'h6});
    stb(1'b0, 1);
    stb(1'b1, 7);
    cb(sg, 1'b1);
    stb(1'b1, 1);
    cb(sg, 1'b0);
    summarize();
  end
endmodule : dcaa_top_tb_top
